// ===== hw/dssc_pkg.sv
package dssc_pkg;

  // chain and bus geometry
  localparam int CHAIN_LEN = 33;
  localparam int DATA_W = 32;
  localparam int CNT_W = 6;
  localparam int MODE_W = 5;
  localparam int ADDR_W = 8;

  // synchronised entry events
  localparam int EVT_W = 3;
  localparam int EVT_BKPT = 0;
  localparam int EVT_WATCH = 1;
  localparam int EVT_DREQ = 2;

  // tap instruction that releases the core
  localparam logic [3:0] IR_RESTART = 4'h4;

  // transfer type encodings
  localparam logic [1:0] TT_MEM = 2'h0;
  localparam logic [1:0] TT_NSEQ = 2'h2;
  localparam logic [1:0] TT_IDLE = 2'h3;

  // program counter steps, in words of four bytes
  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam logic [31:0] PC_ENTRY_WORDS = 32'h4;
  localparam logic [31:0] PC_DREQ_WORDS = 32'h3;
  localparam logic [31:0] PC_SYS_WORDS = 32'h3;
  localparam logic [31:0] PC_INSN_WORDS = 32'h1;
  localparam logic [31:0] PC_RESET = 32'h0;
  localparam logic [4:0] MODE_RESET = 5'h00;

  // register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0c;
  localparam int CTRL_FORCE_ACK = 0;

  // instruction decode fields
  localparam int OPC_TOP = 27;
  localparam int PSR_TOP = 21;
  localparam logic [2:0] OPC_BRANCH = 3'h5;
  localparam logic [2:0] OPC_LDM = 3'h4;
  localparam logic [1:0] OPC_LDST = 2'h1;
  localparam logic [4:0] OPC_PSR = 5'h02;
  localparam logic [1:0] PSR_WRITE = 2'h2;

  // gray codes along run, debug, hold, access
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_DEBUG = 3'h1,
    ST_SYS_HOLD = 3'h3,
    ST_SYS_ACC = 3'h2,
    ST_EXIT_HOLD = 3'h5
  } dssc_state_t;

endpackage

// ===== hw/dssc_evt_if.sv
`timescale 1ns/100ps
interface dssc_evt_if;
  logic [dssc_pkg::EVT_W-1:0] evt;
  modport src (output evt);
  modport dst (input evt);
endinterface

// ===== hw/dssc_sync.sv
`timescale 1ns/100ps
module dssc_sync #(
  parameter int W = dssc_pkg::EVT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic [W-1:0] raw,
  // settled levels
  dssc_evt_if.src ev
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;

  // a bit moves only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
    end
  end

  assign ev.evt = q_reg;

endmodule

// ===== hw/dssc_top.sv
`timescale 1ns/100ps
module dssc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [dssc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // entry event pins
  input wire logic break_control_input,
  input wire logic watch_hit,
  input wire logic debug_request,
  // core state at entry
  input wire logic core_narrow,
  input wire logic [dssc_pkg::MODE_W-1:0] core_mode,
  // clock qualifiers
  input wire logic test_clock_qualifier,
  input wire logic system_clock_qualifier,
  // tap controls
  input wire logic [3:0] tap_ir,
  input wire logic tap_chain1,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_run_idle,
  input wire logic tdi,
  output logic tdo,
  // data bus cells
  input wire logic [dssc_pkg::DATA_W-1:0] data_in,
  output logic [dssc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  // core side
  output logic debug_acknowledge,
  output logic [1:0] transfer_type,
  output logic fetch_enable,
  output logic pipe_flush,
  output logic exec_strobe,
  output logic [dssc_pkg::DATA_W-1:0] exec_word,
  output logic [dssc_pkg::MODE_W-1:0] cur_mode
);

  localparam int LEN = dssc_pkg::CHAIN_LEN;
  localparam int DW = dssc_pkg::DATA_W;

  dssc_evt_if evt_if ();

  dssc_sync #(.W(dssc_pkg::EVT_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({debug_request, watch_hit, break_control_input}),
    .ev(evt_if.src)
  );

  dssc_pkg::dssc_state_t state_reg, state_next;
  logic [LEN-1:0] sc_reg;
  logic [dssc_pkg::CNT_W-1:0] cnt_reg;
  logic sys_next_reg;
  logic first_cap_reg;
  logic cause_reg;
  logic sys_ret_reg;
  logic narrow_reg;
  logic [dssc_pkg::MODE_W-1:0] mode_reg;
  logic [31:0] pc_reg;
  logic [DW-1:0] held_reg;
  logic acc_go_reg;
  logic ack_reg;
  logic [1:0] tt_reg;
  logic fetch_reg;
  logic flush_reg;
  logic exec_reg;
  logic [DW-1:0] exec_word_reg;
  logic [DW-1:0] dout_reg;
  logic oe_n_reg;
  logic force_ack_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic [dssc_pkg::EVT_W-1:0] ev;
  logic enter;
  logic step;
  logic restart_go;
  logic acc_done;
  logic [DW-1:0] word;
  logic is_branch;
  logic is_ldst;
  logic is_psr_wr;
  logic is_store;
  logic cap;
  logic apb_wr;

  assign ev = evt_if.evt;
  assign enter = state_reg == dssc_pkg::ST_RUN && (|ev);
  assign word = sc_reg[DW-1:0];
  assign is_branch = word[dssc_pkg::OPC_TOP -: 3] == dssc_pkg::OPC_BRANCH;
  assign is_ldst = word[dssc_pkg::OPC_TOP -: 2] == dssc_pkg::OPC_LDST ||
                   word[dssc_pkg::OPC_TOP -: 3] == dssc_pkg::OPC_LDM;
  assign is_psr_wr = word[dssc_pkg::OPC_TOP -: 5] == dssc_pkg::OPC_PSR &&
                     word[dssc_pkg::PSR_TOP -: 2] == dssc_pkg::PSR_WRITE;
  // load bit is the lower bit of the psr write field
  assign is_store = !held_reg[dssc_pkg::PSR_TOP - 1];
  assign cap = tap_chain1 && tap_capture_dr && test_clock_qualifier;
  // a core step needs a full chain word shifted since capture
  assign step = state_reg == dssc_pkg::ST_DEBUG && tap_chain1 &&
                tap_update_dr && test_clock_qualifier &&
                cnt_reg == dssc_pkg::CNT_W'(LEN);
  // release waits for run-test/idle so several cores start together
  assign restart_go = tap_ir == dssc_pkg::IR_RESTART && tap_run_idle;
  assign acc_done = state_reg == dssc_pkg::ST_SYS_ACC && acc_go_reg &&
                    system_clock_qualifier;
  assign apb_wr = psel && penable && pwrite;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dssc_pkg::ST_RUN: begin
        if (enter) begin
          state_next = dssc_pkg::ST_DEBUG;
        end
      end
      dssc_pkg::ST_DEBUG: begin
        // bit 33 on the previous word selects system speed
        if (step && sys_next_reg && is_branch) begin
          state_next = dssc_pkg::ST_EXIT_HOLD;
        end else if (step && sys_next_reg && is_ldst) begin
          state_next = dssc_pkg::ST_SYS_HOLD;
        end
      end
      dssc_pkg::ST_SYS_HOLD: begin
        if (restart_go) begin
          state_next = dssc_pkg::ST_SYS_ACC;
        end
      end
      dssc_pkg::ST_SYS_ACC: begin
        if (acc_done) begin
          state_next = dssc_pkg::ST_DEBUG;
        end
      end
      dssc_pkg::ST_EXIT_HOLD: begin
        if (restart_go) begin
          state_next = dssc_pkg::ST_RUN;
        end
      end
      default: state_next = dssc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dssc_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // scan chain: tdi enters data bit 0, break cell leaves first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_reg <= '0;
      cnt_reg <= '0;
    end else if (cap) begin
      sc_reg <= {first_cap_reg ? cause_reg :
                 (sys_ret_reg || ev[dssc_pkg::EVT_BKPT]), data_in};
      cnt_reg <= '0;
    end else if (tap_chain1 && tap_shift_dr && test_clock_qualifier) begin
      sc_reg <= {sc_reg[LEN-2:0], tdi};
      if (cnt_reg != '1) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign tdo = sc_reg[LEN-1];

  // entry cause, capture history and system-return flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_cap_reg <= 1'b0;
      cause_reg <= 1'b0;
      sys_ret_reg <= 1'b0;
      narrow_reg <= 1'b0;
      sys_next_reg <= 1'b0;
    end else begin
      if (enter) begin
        first_cap_reg <= 1'b1;
        cause_reg <= ev[dssc_pkg::EVT_WATCH];
        narrow_reg <= core_narrow;
        sys_next_reg <= 1'b0;
      end else if (cap) begin
        first_cap_reg <= 1'b0;
      end
      // return beats a capture in the same cycle
      if (acc_done) begin
        sys_ret_reg <= 1'b1;
      end else if (cap) begin
        sys_ret_reg <= 1'b0;
      end
      if (step) begin
        sys_next_reg <= sc_reg[LEN-1];
      end
    end
  end

  // program counter bookkeeping and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= dssc_pkg::PC_RESET;
      mode_reg <= dssc_pkg::MODE_RESET;
    end else if (enter) begin
      mode_reg <= core_mode;
      if (ev[dssc_pkg::EVT_BKPT] || ev[dssc_pkg::EVT_WATCH]) begin
        pc_reg <= 32'(pc_reg + dssc_pkg::PC_ENTRY_WORDS *
                                dssc_pkg::WORD_BYTES);
      end else begin
        pc_reg <= 32'(pc_reg + dssc_pkg::PC_DREQ_WORDS *
                                dssc_pkg::WORD_BYTES);
      end
    end else if (step) begin
      // a held system-speed word is counted when its access completes
      if (!(sys_next_reg && is_ldst)) begin
        pc_reg <= 32'(pc_reg + dssc_pkg::PC_INSN_WORDS *
                                dssc_pkg::WORD_BYTES);
      end
      // privilege is not checked while halted
      if (is_psr_wr && !sys_next_reg) begin
        mode_reg <= word[dssc_pkg::MODE_W-1:0];
      end
    end else if (acc_done) begin
      pc_reg <= 32'(pc_reg + dssc_pkg::PC_SYS_WORDS *
                              dssc_pkg::WORD_BYTES);
    end else if (apb_wr && paddr == dssc_pkg::REG_PC) begin
      pc_reg <= pwdata;
    end
  end

  // debug-speed execution and system-speed hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_reg <= 1'b0;
      exec_word_reg <= '0;
      held_reg <= '0;
    end else begin
      exec_reg <= step && !(sys_next_reg && (is_branch || is_ldst));
      if (step) begin
        exec_word_reg <= word;
      end
      if (step && sys_next_reg && is_ldst) begin
        held_reg <= word;
      end
    end
  end

  // system-speed access: resync on the system qualifier first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_go_reg <= 1'b0;
      dout_reg <= '0;
      oe_n_reg <= 1'b1;
    end else begin
      if (state_reg == dssc_pkg::ST_SYS_ACC && system_clock_qualifier &&
          !acc_go_reg) begin
        acc_go_reg <= 1'b1;
        dout_reg <= exec_word_reg;
        oe_n_reg <= !is_store;
      end else if (acc_done || state_reg != dssc_pkg::ST_SYS_ACC) begin
        acc_go_reg <= 1'b0;
        oe_n_reg <= 1'b1;
      end
    end
  end

  // acknowledge, transfer type, fetch and flush outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      tt_reg <= dssc_pkg::TT_NSEQ;
      fetch_reg <= 1'b1;
      flush_reg <= 1'b0;
    end else begin
      ack_reg <= (state_next != dssc_pkg::ST_RUN &&
                  state_next != dssc_pkg::ST_SYS_ACC) ||
                 (state_next == dssc_pkg::ST_SYS_ACC &&
                  force_ack_reg);
      // fetch lags the acknowledge edge by one cycle on entry and exit; it stays low through a system access
      fetch_reg <= state_reg == dssc_pkg::ST_RUN;
      flush_reg <= enter;
      if (state_next == dssc_pkg::ST_RUN) begin
        tt_reg <= dssc_pkg::TT_NSEQ;
      // held low while the system qualifier stalls the access
      end else if (state_reg == dssc_pkg::ST_SYS_ACC && !acc_done &&
                   (system_clock_qualifier || acc_go_reg)) begin
        tt_reg <= dssc_pkg::TT_MEM;
      end else begin
        tt_reg <= dssc_pkg::TT_IDLE;
      end
    end
  end

  // apb: zero wait, read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_ack_reg <= 1'b0;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      if (apb_wr && paddr == dssc_pkg::REG_CTRL) begin
        force_ack_reg <= pwdata[dssc_pkg::CTRL_FORCE_ACK];
      end
      if (psel && !penable) begin
        pslverr_reg <= 1'b0;
        prdata_reg <= '0;
        unique case (paddr)
          dssc_pkg::REG_CTRL: prdata_reg <= {31'h0, force_ack_reg};
          dssc_pkg::REG_STATUS: prdata_reg <= {27'h0, narrow_reg, tt_reg,
                                  state_reg != dssc_pkg::ST_RUN,
                                  ack_reg};
          dssc_pkg::REG_PC: prdata_reg <= pc_reg;
          dssc_pkg::REG_MODE: prdata_reg <= {27'h0, mode_reg};
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = penable;
  assign pslverr = pslverr_reg && psel && penable;
  assign data_out = dout_reg;
  assign data_oe_n = oe_n_reg;
  assign debug_acknowledge = ack_reg;
  assign transfer_type = tt_reg;
  assign fetch_enable = fetch_reg;
  assign pipe_flush = flush_reg;
  assign exec_strobe = exec_reg;
  assign exec_word = exec_word_reg;
  assign cur_mode = mode_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ack_held;
    state_reg == dssc_pkg::ST_DEBUG && $past(state_reg) ==
      dssc_pkg::ST_DEBUG |-> debug_acknowledge;
  endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("acknowledge low in debug state");

  property p_entry_pc;
    enter && !ev[dssc_pkg::EVT_DREQ] |=> pc_reg == 32'($past(pc_reg) + 16);
  endproperty
  a_entry_pc: assert property (p_entry_pc)
    else $error("entry pc step wrong");

  property p_step_pc;
    step && !(sys_next_reg && is_ldst)
      |=> pc_reg == 32'($past(pc_reg) + 4);
  endproperty
  a_step_pc: assert property (p_step_pc)
    else $error("debug step pc wrong");

  property p_last_fetch;
    $rose(debug_acknowledge) && $past(state_reg) == dssc_pkg::ST_RUN
      |-> fetch_enable ##1 !fetch_enable;
  endproperty
  a_last_fetch: assert property (p_last_fetch)
    else $error("last access timing wrong");

  property p_first_fetch;
    $fell(debug_acknowledge) && state_reg == dssc_pkg::ST_RUN
      |-> !fetch_enable ##1 fetch_enable;
  endproperty
  a_first_fetch: assert property (p_first_fetch)
    else $error("first access timing wrong");

  property p_sys_tt;
    state_reg == dssc_pkg::ST_SYS_ACC && acc_go_reg
      |-> transfer_type == dssc_pkg::TT_MEM;
  endproperty
  a_sys_tt: assert property (p_sys_tt)
    else $error("transfer type not low during access");

  property p_sys_done;
    acc_done |=> debug_acknowledge && transfer_type == 2'h3 &&
      state_reg == dssc_pkg::ST_DEBUG && sys_ret_reg;
  endproperty
  a_sys_done: assert property (p_sys_done)
    else $error("access completion wrong");

  property p_hold_exit;
    state_reg == dssc_pkg::ST_EXIT_HOLD && !tap_run_idle
      |=> state_reg == dssc_pkg::ST_EXIT_HOLD && !fetch_enable;
  endproperty
  a_hold_exit: assert property (p_hold_exit)
    else $error("resumed before run-test/idle");

  property p_flush;
    enter |=> pipe_flush ##1 !pipe_flush;
  endproperty
  a_flush: assert property (p_flush)
    else $error("pipeline flush pulse wrong");

  property p_force;
    state_reg == dssc_pkg::ST_SYS_ACC && $past(force_ack_reg) &&
      force_ack_reg |-> debug_acknowledge;
  endproperty
  a_force: assert property (p_force)
    else $error("forced acknowledge low");

  property p_narrow;
    enter |=> narrow_reg == $past(core_narrow);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("entry state bit wrong");

  property p_sys_start;
    state_reg == dssc_pkg::ST_SYS_HOLD && restart_go
      |=> state_reg == dssc_pkg::ST_SYS_ACC;
  endproperty
  a_sys_start: assert property (p_sys_start)
    else $error("restart did not start access");

  c_entry: cover property (enter ##[1:200] step);
  c_sys: cover property (acc_done);
  c_exit: cover property (state_reg == dssc_pkg::ST_EXIT_HOLD &&
                          state_next == dssc_pkg::ST_RUN);
  c_watch: cover property (enter && ev[dssc_pkg::EVT_WATCH]);

endmodule

// ===== tb/dssc_dbg_model.sv
`timescale 1ns/100ps
module dssc_dbg_model (
  // clock
  input wire logic pclk,
  // tap side
  output logic [3:0] tap_ir,
  output logic tap_chain1,
  output logic tap_capture_dr,
  output logic tap_shift_dr,
  output logic tap_update_dr,
  output logic tap_run_idle,
  output logic test_clock_qualifier,
  output logic tdi,
  input wire logic tdo
);
  // internal-test code, value arbitrary, anything but restart
  localparam logic [3:0] IR_TEST = 4'hc;

  initial begin
    tap_ir = IR_TEST;
    tap_chain1 = 1'b1;
    {tap_capture_dr, tap_shift_dr, tap_update_dr} = 3'h0;
    tap_run_idle = 1'b0;
    test_clock_qualifier = 1'b0;
    tdi = 1'b0;
  end

  // one qualified step, then an idle cycle; tdi turned over when unused
  task tck(input logic [2:0] csu, input logic d);
    {tap_capture_dr, tap_shift_dr, tap_update_dr} <= csu;
    tdi <= d;
    test_clock_qualifier <= 1'b1;
    @(posedge pclk);
    {tap_capture_dr, tap_shift_dr, tap_update_dr} <= 3'h0;
    tdi <= ~d;
    test_clock_qualifier <= 1'b0;
    @(posedge pclk);
  endtask

  // callers scan data, load/store, status transfer and branch words
  task scan(input logic b, input logic [31:0] w, input int n,
            output logic [32:0] got);
    logic [32:0] sh;
    sh = {b, w};
    got = '0;
    tck(3'h4, 1'b0);
    for (int k = 0; k < 33; k++) begin
      got = {got[31:0], tdo};
      if (k < n)
        tck(3'h2, sh[32-k]);
    end
    tck(3'h1, 1'b0);
  endtask

  // a 16-bit instruction goes in both halves of the word
  task scan_half(input logic b, input logic [15:0] h,
                 output logic [32:0] got);
    scan(b, {h, h}, 33, got);
  endtask

  // restart code, run-test/idle only when asked
  task restart(input logic idle);
    tap_ir <= dssc_pkg::IR_RESTART;
    tap_run_idle <= idle;
    @(posedge pclk);
    tap_run_idle <= 1'b0;
    tap_ir <= IR_TEST;
    @(posedge pclk);
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] NOP = 32'he1a00000;
  localparam logic [31:0] STR = 32'he5801000;
  localparam logic [31:0] BRA = 32'heafffff9;
  localparam logic [31:0] MODE_FIQ_WR = 32'he129f011;
  localparam logic [31:0] MODE_USR_WR = 32'he129f010;
  localparam logic [31:0] STORE_MULTI = 32'he8800003;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, watch;
  logic brk, watch_hit, debug_request, core_narrow, sysq, tdo, data_oe_n;
  logic tap_chain1, cap, shf, upd, run_idle, tcq, tdi;
  logic debug_acknowledge, fetch_enable, pipe_flush, exec_strobe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, data_in, data_out, exec_word, rv, last_word;
  logic [4:0] core_mode, cur_mode;
  logic [3:0] tap_ir;
  logic [1:0] transfer_type;
  logic [32:0] g;
  int mismatches, total_checks, execs, flushes, drops, n;

  dssc_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .break_control_input(brk), .watch_hit(watch_hit),
    .debug_request(debug_request), .core_narrow(core_narrow),
    .core_mode(core_mode), .test_clock_qualifier(tcq),
    .system_clock_qualifier(sysq), .tap_ir(tap_ir),
    .tap_chain1(tap_chain1), .tap_capture_dr(cap), .tap_shift_dr(shf),
    .tap_update_dr(upd), .tap_run_idle(run_idle), .tdi(tdi), .tdo(tdo),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .debug_acknowledge(debug_acknowledge), .transfer_type(transfer_type),
    .fetch_enable(fetch_enable), .pipe_flush(pipe_flush),
    .exec_strobe(exec_strobe), .exec_word(exec_word), .cur_mode(cur_mode));

  dssc_dbg_model dbg_u (.pclk(pclk), .tap_ir(tap_ir),
    .tap_chain1(tap_chain1), .tap_capture_dr(cap), .tap_shift_dr(shf),
    .tap_update_dr(upd), .tap_run_idle(run_idle),
    .test_clock_qualifier(tcq), .tdi(tdi), .tdo(tdo));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (exec_strobe === 1'b1) begin
      execs <= execs + 1;
      last_word <= exec_word;
    end
    if (pipe_flush === 1'b1)
      flushes <= flushes + 1;
    // forced acknowledge must never dip during a watched access
    if (watch && debug_acknowledge !== 1'b1)
      drops <= drops + 1;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask

  task wait_ack(input logic v);
    for (n = 0; n < 40 && debug_acknowledge !== v; n++)
      @(posedge pclk);
    chk(debug_acknowledge, {31'h0, v});
  endtask

  task enter(input int which);
    brk <= (which == 0);
    watch_hit <= (which == 1);
    debug_request <= (which == 2);
    wait_ack(1'b1);
    chk(fetch_enable, 32'h1);
    chk(transfer_type, 32'h3);
    {brk, watch_hit, debug_request} <= 3'h0;
    @(posedge pclk);
    chk(fetch_enable, 32'h0);
  endtask

  task sys_access(input logic forced, input logic [31:0] insn);
    dbg_u.scan(1'b1, insn, 33, g);
    dbg_u.scan(1'b0, insn, 33, g);
    dbg_u.restart(1'b1);
    repeat (2) @(posedge pclk);
    chk(debug_acknowledge, forced);
    chk(transfer_type, 32'h3);
    sysq <= 1'b1;
    @(posedge pclk);
    sysq <= 1'b0;
    @(posedge pclk);
    chk(transfer_type, 32'h0);
    chk(data_oe_n, 32'h0);
    chk(data_out, insn);
    // stalled qualifier: the access must simply wait
    repeat (3) @(posedge pclk);
    chk(transfer_type, 32'h0);
    sysq <= 1'b1;
    for (n = 0; n < 40 && {transfer_type, debug_acknowledge} !== 3'h7; n++)
      @(posedge pclk);
    sysq <= 1'b0;
    chk({transfer_type, debug_acknowledge}, 32'h7);
  endtask

  task leave();
    dbg_u.scan(1'b1, NOP, 33, g);
    dbg_u.scan(1'b0, BRA, 33, g);
    dbg_u.restart(1'b0);
    chk(debug_acknowledge, 32'h1);
    dbg_u.restart(1'b1);
    wait_ack(1'b0);
    chk(fetch_enable, 32'h0);
    @(posedge pclk);
    chk(fetch_enable, 32'h1);
    chk(transfer_type, 32'h2);
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, watch} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {brk, watch_hit, debug_request, sysq} = 4'h0;
    core_narrow = 1'b1;
    core_mode = 5'h10;
    data_in = 32'h5a5a3c3c;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(dssc_pkg::REG_STATUS, 32'h8);
    apb(1'b1, 8'h10, 32'h1);
    chk(err, 32'h1);
    apb(1'b1, dssc_pkg::REG_CTRL, 32'h1);
    rd(dssc_pkg::REG_CTRL, 32'h1);
    apb(1'b1, dssc_pkg::REG_CTRL, 32'h0);
    $display("test registers done");
    enter(0);
    chk(flushes, 32'h1);
    rd(dssc_pkg::REG_STATUS, 32'h1f);
    rd(dssc_pkg::REG_PC, 32'h10);
    dbg_u.scan(1'b0, MODE_FIQ_WR, 33, g);
    chk(g[32], 32'h0);
    chk(g[31:0], 32'h5a5a3c3c);
    for (n = 0; n < 20 && execs == 0; n++)
      @(posedge pclk);
    chk(last_word, MODE_FIQ_WR);
    chk(cur_mode, 32'h11);
    rd(dssc_pkg::REG_MODE, 32'h11);
    rd(dssc_pkg::REG_PC, 32'h14);
    dbg_u.scan(1'b0, NOP, 32, g);
    repeat (4) @(posedge pclk);
    chk(execs, 32'h1);
    $display("test breakpoint entry done");
    sys_access(1'b0, STR);
    rd(dssc_pkg::REG_PC, 32'h24);
    dbg_u.scan_half(1'b0, 16'h46c0, g);
    chk(g[32], 32'h1);
    chk(exec_word, 32'h46c046c0);
    apb(1'b1, dssc_pkg::REG_CTRL, 32'h1);
    watch <= 1'b1;
    sys_access(1'b1, STORE_MULTI);
    watch <= 1'b0;
    chk(drops, 32'h0);
    apb(1'b1, dssc_pkg::REG_CTRL, 32'h0);
    $display("test system access done");
    dbg_u.scan(1'b0, MODE_USR_WR, 33, g);
    repeat (3) @(posedge pclk);
    chk(cur_mode, 32'h10);
    leave();
    $display("test exit done");
    core_narrow <= 1'b0;
    apb(1'b1, dssc_pkg::REG_PC, 32'h100);
    enter(1);
    rd(dssc_pkg::REG_PC, 32'h110);
    rd(dssc_pkg::REG_STATUS, 32'h0f);
    dbg_u.scan(1'b0, NOP, 33, g);
    chk(g[32], 32'h1);
    leave();
    apb(1'b1, dssc_pkg::REG_PC, 32'h200);
    enter(2);
    rd(dssc_pkg::REG_PC, 32'h20c);
    dbg_u.scan(1'b0, NOP, 33, g);
    chk(g[32], 32'h0);
    leave();
    chk(flushes, 32'h3);
    $display("test watch and request entry done");
    wrap_up();
  end
endmodule
